/* File: logic/sst_pkg.sv */
package sst_pkg;
    // Synchronised pin bundle layout
    localparam int          PIN_W       = 22;
    localparam int          P_TXCLK     = 0;
    localparam int          P_RXCLK     = 1;
    localparam int          P_RXIN      = 2;
    localparam int          P_TXLD      = 3;
    localparam int          P_FILLLD    = 4;
    localparam int          P_SYNCLD    = 5;
    localparam int          P_CTRL      = 6;
    localparam int          P_LEN1      = 7;
    localparam int          P_LEN2      = 8;
    localparam int          P_PARDIS    = 9;
    localparam int          P_PAREVEN   = 10;
    localparam int          P_STATN     = 11;
    localparam int          P_RDATN     = 12;
    localparam int          P_RSTRTN    = 13;
    localparam int          P_CHAR      = 14;
    // Idle levels: active-low strobes high, serial input marking
    localparam logic [21:0] PIN_IDLE    = 22'h00383C;

    // Status word positions on the output bus
    localparam int          ST_AVAIL    = 0;
    localparam int          ST_OVR      = 1;
    localparam int          ST_PERR     = 2;
    localparam int          ST_SYNC     = 3;
    localparam int          ST_FILL     = 6;
    localparam int          ST_TBE      = 7;

    // Configuration reset values and character sizing
    localparam logic [1:0]  LEN_RESET     = 2'h3;
    localparam logic        PARDIS_RESET  = 1'b1;
    localparam logic        PAREVEN_RESET = 1'b1;
    localparam logic [3:0]  MIN_BITS      = 4'h5;
    localparam logic [3:0]  MAX_BITS      = 4'h8;
    localparam logic [8:0]  TX_RESET_CHAR = 9'h1FF;
    localparam int          FIFO_DEPTH    = 8;

    typedef enum logic [2:0] {
        RX_OFF   = 3'b001,
        RX_HUNT  = 3'b010,
        RX_FRAME = 3'b100
    } sst_rx_state_t;
endpackage : sst_pkg

/* File: logic/sst_fifo.sv */
`timescale 1ns/10ps
module sst_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_reg;
    logic [AW-1:0]    rdPtr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    // Honest flags straight from the occupancy count
    assign inReady  = (count_reg != (AW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData  = mem[rdPtr_reg];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    // Storage has no reset; only the pointers and count need a defined start
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
            end
            if (pop) begin
                rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : sst_fifo

/* File: logic/sst_transceiver.sv */
`timescale 1ns/10ps
// Function
// - One NRZ bit per own bit clock
// - Length and parity shared by both directions
// - Hunt sync each bit, then frame characters
// - Received character held in output register
// - Odd, even or no parity, generated and checked
// - Serial output changes on transmit clock rise
// - LSB first, from holding or fill register
// - Fill character sent when nothing loaded
// - Load strobe latches holding, clears buffer empty
// - Buffer empty set on move to shifter
// - Fill and sync strobes latch their registers
// - Input right justified, upper bits ignored
// - Sync flag set when shifter equals sync
// - Reset sends ones, clears fill, sets empty
// - Reset clears flags, halts hunt until restart
// - Transmission starts on first clock rise
// - Status word layout on output bus
// - Data word or tri-state on output bus
// - Receiver samples on bit clock fall
// - Data available set, cleared by read/restart
// - Overrun when a full store replaces an unread character
// - Status read end clears flags; fill flag
module sst_transceiver #(
    parameter int FIFO_DEPTH = sst_pkg::FIFO_DEPTH
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       txBitClock,
    input  wire logic       rxBitClock,
    input  wire logic       rxSerialIn,
    input  wire logic [7:0] charInBus,
    input  wire logic       txCharLoadN,
    input  wire logic       fillCharLoadN,
    input  wire logic       syncCharLoadN,
    input  wire logic       controlStrobe,
    input  wire logic       charLenSel1,
    input  wire logic       charLenSel2,
    input  wire logic       parityDisable,
    input  wire logic       parityOddEvenSel,
    input  wire logic       statusOutEnableN,
    input  wire logic       rxDataOutN,
    input  wire logic       rxRestartN,
    output logic            txSerialOut,
    output logic      [7:0] rxOutBus,
    output logic            rxOutBusOeN,
    output logic            txBufferEmpty,
    output logic            fillSentFlag,
    output logic            rxDataAvail,
    output logic            rxOverrun,
    output logic            rxParityError,
    output logic            syncMatchFlag
);
    logic [sst_pkg::PIN_W-1:0] pinA_reg, pinB_reg, pinC_reg;
    logic [7:0]                charIn, charMask, hold_reg, fill_reg, sync_reg;
    logic                      txTick, rxTick, statRise, dataRise, restartLow;
    logic [1:0]                charLen_reg;
    logic                      parityOff_reg, parityEven_reg;
    logic [3:0]                dataBits, frameBits, txLeft_reg, rxCount_reg;
    logic [8:0]                txShift_reg, txFrame, fifoOutData;
    logic                      txSlot, txOut_reg, txEmpty_reg, fillSent_reg;
    sst_pkg::sst_rx_state_t    rxState_reg;
    logic [7:0]                rxShift_reg, rxChar, rxOut_reg, bus_reg;
    logic                      rxParBit_reg, rxStep_reg, rxDone_reg, syncHit, rxParErr;
    logic                      fifoInReady, fifoOutValid, fifoOutReady, pop;
    logic                      avail_reg, overrun_reg, parErr_reg, syncFlag_reg, busOeN_reg;

    // Two-stage synchroniser for every pin; stage C only feeds edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            pinA_reg <= sst_pkg::PIN_IDLE;
            pinB_reg <= sst_pkg::PIN_IDLE;
            pinC_reg <= sst_pkg::PIN_IDLE;
        end else begin
            pinA_reg <= {charInBus, rxRestartN, rxDataOutN, statusOutEnableN,
                         parityOddEvenSel, parityDisable, charLenSel2, charLenSel1,
                         controlStrobe, syncCharLoadN, fillCharLoadN, txCharLoadN,
                         rxSerialIn, rxBitClock, txBitClock};
            pinB_reg <= pinA_reg;
            pinC_reg <= pinB_reg;
        end
    end

    // Edge and level decodes of the synchronised pins
    assign charIn     = pinB_reg[sst_pkg::P_CHAR +: 8];
    assign txTick     = pinB_reg[sst_pkg::P_TXCLK] & ~pinC_reg[sst_pkg::P_TXCLK];
    assign rxTick     = ~pinB_reg[sst_pkg::P_RXCLK] & pinC_reg[sst_pkg::P_RXCLK];
    assign statRise   = pinB_reg[sst_pkg::P_STATN] & ~pinC_reg[sst_pkg::P_STATN];
    assign dataRise   = pinB_reg[sst_pkg::P_RDATN] & ~pinC_reg[sst_pkg::P_RDATN];
    assign restartLow = ~pinB_reg[sst_pkg::P_RSTRTN];

    // Shared character format, latched while the control strobe is high
    always_ff @(posedge clk) begin
        if (rst) begin
            charLen_reg    <= sst_pkg::LEN_RESET;
            parityOff_reg  <= sst_pkg::PARDIS_RESET;
            parityEven_reg <= sst_pkg::PAREVEN_RESET;
        end else if (pinB_reg[sst_pkg::P_CTRL]) begin
            charLen_reg    <= {pinB_reg[sst_pkg::P_LEN2], pinB_reg[sst_pkg::P_LEN1]};
            parityOff_reg  <= pinB_reg[sst_pkg::P_PARDIS];
            parityEven_reg <= pinB_reg[sst_pkg::P_PAREVEN];
        end
    end

    // One format drives both directions
    assign dataBits  = sst_pkg::MIN_BITS + {2'h0, charLen_reg};
    assign frameBits = dataBits + {3'h0, ~parityOff_reg};
    assign charMask  = 8'hFF >> (sst_pkg::MAX_BITS - dataBits);

    // Masks the character and appends parity just above its top bit
    function automatic logic [8:0] makeFrame(input logic [7:0] c);
        logic [8:0] f;
        f = {1'b0, c & charMask};
        if (!parityOff_reg) begin
            f[dataBits] = (^(c & charMask)) ^ ~parityEven_reg;
        end
        return f;
    endfunction : makeFrame

    // Character registers written straight from the input bus
    always_ff @(posedge clk) begin
        if (!pinB_reg[sst_pkg::P_TXLD]) begin
            hold_reg <= charIn;
        end
        if (!pinB_reg[sst_pkg::P_FILLLD]) begin
            fill_reg <= charIn;
        end
        if (!pinB_reg[sst_pkg::P_SYNCLD]) begin
            sync_reg <= charIn;
        end
    end

    // Transmit shifter: a new character is taken only when the last bit is out
    assign txSlot  = txTick & (txLeft_reg == 4'h0);
    always_comb begin
        txFrame = makeFrame(txEmpty_reg ? fill_reg : hold_reg);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            txShift_reg <= sst_pkg::TX_RESET_CHAR;
            txLeft_reg  <= sst_pkg::MAX_BITS;
            txOut_reg   <= 1'b1;
        end else if (txSlot) begin
            txOut_reg   <= txFrame[0];
            txShift_reg <= txFrame >> 1;
            txLeft_reg  <= frameBits - 4'h1;
        end else if (txTick) begin
            txOut_reg   <= txShift_reg[0];
            txShift_reg <= txShift_reg >> 1;
            txLeft_reg  <= txLeft_reg - 4'h1;
        end
    end

    // Buffer empty: the hardware set beats a load in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            txEmpty_reg <= 1'b1;
        end else if (txSlot && !txEmpty_reg) begin
            txEmpty_reg <= 1'b1;
        end else if (!pinB_reg[sst_pkg::P_TXLD]) begin
            txEmpty_reg <= 1'b0;
        end
    end

    // Fill flag follows the source of each slot; a status read clears it
    always_ff @(posedge clk) begin
        if (rst) begin
            fillSent_reg <= 1'b0;
        end else if (txSlot) begin
            fillSent_reg <= txEmpty_reg;
        end else if (statRise) begin
            fillSent_reg <= 1'b0;
        end
    end

    // Receiver view of the shifter, right justified to the character length
    assign rxChar   = rxShift_reg >> (sst_pkg::MAX_BITS - dataBits);
    assign syncHit  = (rxChar == (sync_reg & charMask));
    assign rxParErr = ~parityOff_reg & ((^rxChar) ^ rxParBit_reg ^ ~parityEven_reg);

    // Receive sequencer: off after reset, hunting per bit, then per character
    always_ff @(posedge clk) begin
        if (rst) begin
            rxState_reg  <= sst_pkg::RX_OFF;
            rxShift_reg  <= 8'h00;
            rxCount_reg  <= 4'h0;
            rxParBit_reg <= 1'b0;
            rxStep_reg   <= 1'b0;
            rxDone_reg   <= 1'b0;
        end else begin
            rxStep_reg <= rxTick & (rxState_reg == sst_pkg::RX_HUNT);
            rxDone_reg <= 1'b0;
            if (restartLow) begin
                rxState_reg <= sst_pkg::RX_HUNT;
                rxCount_reg <= 4'h0;
            end else begin
                unique case (rxState_reg)
                    sst_pkg::RX_OFF: begin
                    end
                    sst_pkg::RX_HUNT: begin
                        if (rxTick) begin
                            rxShift_reg <= {pinB_reg[sst_pkg::P_RXIN], rxShift_reg[7:1]};
                        end
                        if (rxStep_reg && syncHit) begin
                            rxState_reg <= sst_pkg::RX_FRAME;
                            rxCount_reg <= 4'h0;
                        end
                    end
                    sst_pkg::RX_FRAME: begin
                        if (rxTick) begin
                            if (rxCount_reg < dataBits) begin
                                rxShift_reg <= {pinB_reg[sst_pkg::P_RXIN], rxShift_reg[7:1]};
                            end else begin
                                rxParBit_reg <= pinB_reg[sst_pkg::P_RXIN];
                            end
                            if (rxCount_reg == frameBits - 4'h1) begin
                                rxCount_reg <= 4'h0;
                                rxDone_reg  <= 1'b1;
                            end else begin
                                rxCount_reg <= rxCount_reg + 4'h1;
                            end
                        end
                    end
                    default: begin
                        rxState_reg <= sst_pkg::RX_OFF;
                    end
                endcase
            end
        end
    end

    // Elastic store between framer and output register; a full store forces
    // a transfer so the host is told of the overrun instead of a silent drop
    assign fifoOutReady = ~avail_reg | ~fifoInReady;
    assign pop          = fifoOutValid & fifoOutReady;

    sst_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH)
    ) u_rxFifo (
        .clk      (clk),
        .rst      (rst),
        .inValid  (rxDone_reg),
        .inReady  (fifoInReady),
        .inData   ({rxParErr, rxChar}),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOutData)
    );

    // Output register gives the host a full character time to read
    always_ff @(posedge clk) begin
        if (rst) begin
            rxOut_reg <= 8'h00;
        end else if (pop) begin
            rxOut_reg <= fifoOutData[7:0];
        end
    end

    // Receive flags: every hardware set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            avail_reg   <= 1'b0;
            overrun_reg <= 1'b0;
            parErr_reg  <= 1'b0;
        end else begin
            if (pop) begin
                avail_reg <= 1'b1;
            end else if (dataRise || restartLow) begin
                avail_reg <= 1'b0;
            end
            if (pop && avail_reg) begin
                overrun_reg <= 1'b1;
            end else if (statRise || restartLow) begin
                overrun_reg <= 1'b0;
            end
            if (pop) begin
                parErr_reg <= fifoOutData[8];
            end else if (statRise || restartLow) begin
                parErr_reg <= 1'b0;
            end
        end
    end

    // Sync flag: checked at every bit while hunting and at every character after
    always_ff @(posedge clk) begin
        if (rst) begin
            syncFlag_reg <= 1'b0;
        end else if ((rxStep_reg || rxDone_reg) && syncHit) begin
            syncFlag_reg <= 1'b1;
        end else if (statRise || restartLow) begin
            syncFlag_reg <= 1'b0;
        end
    end

    // Output bus mux; both enables low is treated as off, as is both high
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_reg    <= 8'h00;
            busOeN_reg <= 1'b1;
        end else begin
            case ({pinB_reg[sst_pkg::P_STATN], pinB_reg[sst_pkg::P_RDATN]})
                2'b01: begin
                    bus_reg <= 8'h00;
                    bus_reg[sst_pkg::ST_AVAIL] <= avail_reg;
                    bus_reg[sst_pkg::ST_OVR]   <= overrun_reg;
                    bus_reg[sst_pkg::ST_PERR]  <= parErr_reg;
                    bus_reg[sst_pkg::ST_SYNC]  <= syncFlag_reg;
                    bus_reg[sst_pkg::ST_FILL]  <= fillSent_reg;
                    bus_reg[sst_pkg::ST_TBE]   <= txEmpty_reg;
                    busOeN_reg <= 1'b0;
                end
                2'b10: begin
                    bus_reg    <= rxOut_reg;
                    busOeN_reg <= 1'b0;
                end
                default: begin
                    bus_reg    <= 8'h00;
                    busOeN_reg <= 1'b1;
                end
            endcase
        end
    end

    assign txSerialOut   = txOut_reg;
    assign rxOutBus      = bus_reg;
    assign rxOutBusOeN   = busOeN_reg;
    assign txBufferEmpty = txEmpty_reg;
    assign fillSentFlag  = fillSent_reg;
    assign rxDataAvail   = avail_reg;
    assign rxOverrun     = overrun_reg;
    assign rxParityError = parErr_reg;
    assign syncMatchFlag = syncFlag_reg;
endmodule : sst_transceiver

/* File: sim/sst_transceiver_assertions.sv */
`timescale 1ns/10ps
module sst_transceiver_checker (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       txBitClock,
    input wire logic       txCharLoadN,
    input wire logic       statusOutEnableN,
    input wire logic       rxDataOutN,
    input wire logic       rxRestartN,
    input wire logic       txSerialOut,
    input wire logic       rxOutBusOeN,
    input wire logic       txBufferEmpty,
    input wire logic       fillSentFlag,
    input wire logic       rxDataAvail,
    input wire logic       rxOverrun,
    input wire logic       rxParityError,
    input wire logic       syncMatchFlag,
    input wire logic [7:0] rxOutBus
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Bus select held past the pin pipe and output register
    sequence s_stat_word; (!statusOutEnableN && rxDataOutN) [*5]; endsequence
    sequence s_read_end; $rose(rxDataOutN); endsequence
    property p_reset_out; $fell(rst) |-> txSerialOut && txBufferEmpty && !fillSentFlag
        && !rxDataAvail && !syncMatchFlag && !rxParityError && rxOutBusOeN; endproperty
    a_reset_out: assert property (p_reset_out) else $error("reset state");
    property p_tbe_clr; $fell(txCharLoadN) |-> ##[1:6] !txBufferEmpty; endproperty
    a_tbe_clr: assert property (p_tbe_clr) else $error("empty not cleared");
    // Output may only move a fixed pipe delay after a bit clock rise
    property p_tx_edge; $changed(txSerialOut) |-> $past(txBitClock, 3); endproperty
    a_tx_edge: assert property (p_tx_edge) else $error("serial out off edge");
    property p_stat; s_stat_word |-> !rxOutBusOeN && rxOutBus[5:4] == 2'h0; endproperty
    a_stat: assert property (p_stat) else $error("status word");
    property p_data; (statusOutEnableN && !rxDataOutN) [*5] |-> !rxOutBusOeN; endproperty
    a_data: assert property (p_data) else $error("data not driven");
    property p_off; (statusOutEnableN && rxDataOutN) [*5] |-> rxOutBusOeN; endproperty
    a_off: assert property (p_off) else $error("bus not released");
    property p_ovr; $rose(rxOverrun) |-> $past(rxDataAvail); endproperty
    a_ovr: assert property (p_ovr) else $error("overrun without unread");
    property p_avail_clr; s_read_end |-> ##[1:6] !rxDataAvail; endproperty
    a_avail_clr: assert property (p_avail_clr) else $error("avail kept");
    property p_stat_clr; $rose(statusOutEnableN) |-> ##[1:6] !rxOverrun && !rxParityError;
    endproperty
    a_stat_clr: assert property (p_stat_clr) else $error("errors kept");
    // Restart strobes last 4 cycles; the clear is visible by the fourth
    property p_restart; !rxRestartN [*4] |-> !rxDataAvail && !rxOverrun && !syncMatchFlag;
    endproperty
    a_restart: assert property (p_restart) else $error("restart no clear");
endmodule : sst_transceiver_checker
bind sst_transceiver sst_transceiver_checker sst_transceiver_checker_inst (.clk, .rst,
    .txBitClock, .txCharLoadN, .statusOutEnableN, .rxDataOutN, .rxRestartN, .txSerialOut,
    .rxOutBusOeN, .txBufferEmpty, .fillSentFlag, .rxDataAvail, .rxOverrun, .rxParityError,
    .syncMatchFlag, .rxOutBus);

/* File: sim/sst_link_peer.sv */
`timescale 1ns/10ps
module sst_link_peer (
    output logic      txBitClock,
    output logic      rxBitClock,
    output logic      rxSerialIn,
    input  wire logic txSerialOut
);
    // Bit clocks stand still low between bursts
    initial begin
        txBitClock = 1'b0;
        rxBitClock = 1'b0;
        rxSerialIn = 1'b1;
    end
    // LSB first, data steady around the sampling fall
    task automatic rx_send(input logic [15:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            rxSerialIn = bits[i];
            #40 rxBitClock = 1'b1;
            #80 rxBitClock = 1'b0;
            #40;
        end
        rxSerialIn = ~bits[n-1]; // Released line shows no stale bit
    endtask : rx_send
    // Sample each bit half a period after its rise, clear of the pipe delay
    task automatic tx_run(input int n, output logic [31:0] bits);
        bits = '0;
        for (int i = 0; i < n; i++) begin
            txBitClock = 1'b1;
            #80 txBitClock = 1'b0;
            bits[i] = txSerialOut;
            #80;
        end
    endtask : tx_run
endmodule : sst_link_peer

/* File: sim/sst_transceiver_tb_top.sv */
`timescale 1ns/10ps
module sst_transceiver_tb_top;
    logic        clk, rst, txBitClock, rxBitClock, rxSerialIn, txSerialOut, rxOutBusOeN;
    logic [7:0]  charInBus, rxOutBus;
    logic        txCharLoadN, fillCharLoadN, syncCharLoadN, controlStrobe, charLenSel1;
    logic        charLenSel2, parityDisable, parityOddEvenSel, statusOutEnableN;
    logic        rxDataOutN, rxRestartN, txBufferEmpty, fillSentFlag, rxDataAvail;
    logic        rxOverrun, rxParityError, syncMatchFlag;
    logic [31:0] txBits;
    int          errCount = 0, checkCount = 0, cycles = 0;
    // Flag snapshot: tso tbe fill avail ovr perr sync oeN
    wire logic [7:0] flg = {txSerialOut, txBufferEmpty, fillSentFlag, rxDataAvail,
        rxOverrun, rxParityError, syncMatchFlag, rxOutBusOeN};

    sst_transceiver #(.FIFO_DEPTH(8)) sst_transceiver_inst (.clk, .rst, .txBitClock,
        .rxBitClock, .rxSerialIn, .charInBus, .txCharLoadN, .fillCharLoadN, .syncCharLoadN,
        .controlStrobe, .charLenSel1, .charLenSel2, .parityDisable, .parityOddEvenSel,
        .statusOutEnableN, .rxDataOutN, .rxRestartN, .txSerialOut, .rxOutBus, .rxOutBusOeN,
        .txBufferEmpty, .fillSentFlag, .rxDataAvail, .rxOverrun, .rxParityError,
        .syncMatchFlag);
    sst_link_peer sst_link_peer_inst (.txBitClock, .rxBitClock, .rxSerialIn, .txSerialOut);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic finishTest();
        $display("errors %0d checks %0d", errCount, checkCount);
        if (errCount == 0 && checkCount > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finishTest

    // Hang guard: the run needs about 2000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errCount++;
            finishTest();
        end
    end

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checkCount++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // Inputs always move 1 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Strobes stay active 4 cycles, above the 3 register pin pipe
    task automatic pulse(ref logic s, input logic lvl, input logic [7:0] d);
        charInBus = d;
        s = lvl;
        tick(4);
        s = ~lvl;
        tick(4);
    endtask : pulse
    task automatic busRead(ref logic en, input logic [7:0] m, input logic [7:0] e, string nm);
        en = 1'b0;
        tick(5);
        check(nm, e, rxOutBus & m);
        en = 1'b1;
        tick(6);
    endtask : busRead

    initial begin
        rst = 1'b1;
        charInBus = 8'h00;
        {txCharLoadN, fillCharLoadN, syncCharLoadN, statusOutEnableN} = 4'hF;
        {rxDataOutN, rxRestartN, controlStrobe} = 3'h6;
        {charLenSel1, charLenSel2, parityDisable, parityOddEvenSel} = 4'h0;
        tick(3);
        rst = 1'b0;
        tick(2);
        check("reset", 8'hC1, flg);
        pulse(fillCharLoadN, 1'b0, 8'hA5);
        pulse(txCharLoadN, 1'b0, 8'h3C);
        check("tbe low", 8'h00, flg & 8'h40);
        sst_link_peer_inst.tx_run(24, txBits);
        check("ones", 8'hFF, txBits[7:0]);
        check("tx data", 8'h3C, txBits[15:8]);
        check("tx fill", 8'hA5, txBits[23:16]);
        check("fill flag", 8'h60, flg & 8'h60);
        // Five bit characters; odd then even parity, upper inputs ignored
        pulse(controlStrobe, 1'b1, 8'h00);
        pulse(txCharLoadN, 1'b0, 8'hF3);
        sst_link_peer_inst.tx_run(6, txBits);
        check("tx odd", 8'h13, txBits[7:0]);
        parityOddEvenSel = 1'b1;
        pulse(controlStrobe, 1'b1, 8'h00);
        pulse(txCharLoadN, 1'b0, 8'h07);
        sst_link_peer_inst.tx_run(6, txBits);
        check("tx even", 8'h27, txBits[7:0]);
        pulse(rxRestartN, 1'b0, 8'h00);
        pulse(syncCharLoadN, 1'b0, 8'hF6);
        sst_link_peer_inst.rx_send(16'h0016, 5);
        tick(4);
        check("sync", 8'h02, flg & 8'h02);
        sst_link_peer_inst.rx_send(16'h002B, 6);
        tick(6);
        check("avail", 8'h10, flg & 8'h1C);
        busRead(rxDataOutN, 8'hFF, 8'h0B, "rx data");
        check("avail clr", 8'h00, flg & 8'h10);
        sst_link_peer_inst.rx_send(16'h0004, 6);
        tick(6);
        busRead(statusOutEnableN, 8'hF7, 8'h85, "status");
        check("status clr", 8'h00, flg & 8'h0E);
        busRead(rxDataOutN, 8'hFF, 8'h04, "bad char");
        // Ten unread characters: a full buffer forces 2 over 1, then 3 over 2
        for (int k = 1; k <= 10; k++) begin
            sst_link_peer_inst.rx_send({10'h000, ^k[4:0], k[4:0]}, 6);
        end
        tick(6);
        check("overrun", 8'h08, flg & 8'h08);
        for (int k = 3; k <= 10; k++) begin
            busRead(rxDataOutN, 8'hFF, 8'(k), "drain");
        end
        check("drained", 8'h00, flg & 8'h10);
        pulse(rxRestartN, 1'b0, 8'h00);
        check("restart", 8'h00, flg & 8'h1E);
        finishTest();
    end
endmodule : sst_transceiver_tb_top
